// File: clk_rst_pkg.sv
// Package: constants, types and decode function of the clock and reset generator
package clk_rst_pkg;
    // Mode and clock control register
    localparam logic [7:0] MODE_ADDR = 8'hEB;
    localparam logic [7:0] MODE_RST = 8'hE0;
    localparam int HALVE_BIT = 5;
    localparam int PRESC_LSB = 2;
    localparam int PRESC_W = 3;
    // Reset exit delay and strobe divider, in oscillator periods
    localparam logic [6:0] EXIT_PERIODS = 7'h43;
    localparam logic [3:0] AS_HALF_LAST = 4'hF;
    // Defaults of registers held elsewhere in the device
    localparam logic [7:0] CIC_RST = 8'h87;
    localparam logic [7:0] WDC_RST = 8'h7F;
    localparam logic [7:0] WDT_CTRL_RST = 8'h12;
    // Reset vector locations
    localparam logic [15:0] VEC_HI_ADDR = 16'h0000;
    localparam logic [15:0] VEC_LO_ADDR = 16'h0001;

    typedef struct packed {
        logic halve;
        logic [PRESC_W-1:0] presc;
    } clk_cfg_t;

    typedef struct packed {
        logic [7:0] core_interrupt_control;
        logic [7:0] watchdog_control;
        logic [7:0] watchdog_timer_control;
    } reg_init_t;

    localparam reg_init_t REG_INIT = '{CIC_RST, WDC_RST, WDT_CTRL_RST};

    typedef enum logic [2:0] {
        V_IDLE = 3'b000,
        V_RD0 = 3'b001,
        V_RD1 = 3'b010,
        V_LOAD = 3'b011,
        V_RUN = 3'b100
    } vec_state_t;

    // Split the mode register into its clock fields
    function automatic clk_cfg_t decode_mode(input logic [7:0] v);
        clk_cfg_t c;
        c.halve = v[HALVE_BIT];
        c.presc = v[PRESC_LSB +: PRESC_W];
        return c;
    endfunction : decode_mode
endpackage : clk_rst_pkg

// File: core_prescaler.sv
// Core clock prescaler with high-phase stretching
`timescale 1ns/100ps
`default_nettype none
module core_prescaler
    import clk_rst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic periph_clk,
    input wire logic periph_rise,
    input wire logic [PRESC_W-1:0] presc,
    input wire logic stretch,
    output logic core_clk
);
    logic [PRESC_W-1:0] ratio_reg;
    logic [PRESC_W-1:0] ratio_next;
    logic [PRESC_W-1:0] cnt_reg;
    logic [PRESC_W-1:0] cnt_next;
    logic core_reg;
    logic core_next;

    // Count peripheral periods; count zero is the single low period
    always_comb begin
        ratio_next = ratio_reg;
        cnt_next = cnt_reg;
        if (periph_rise) begin
            if (stretch && cnt_reg != '0) begin
                cnt_next = cnt_reg;
            end else if (cnt_reg >= ratio_reg) begin
                cnt_next = '0;
                ratio_next = presc;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
        if (ratio_next == '0) begin
            core_next = periph_clk | (stretch & core_reg);
        end else begin
            core_next = (cnt_next != '0);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ratio_reg <= '0;
            cnt_reg <= '0;
            core_reg <= 1'b1;
        end else begin
            ratio_reg <= ratio_next;
            cnt_reg <= cnt_next;
            core_reg <= core_next;
        end
    end

    assign core_clk = core_reg;

    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_stretch_holds_high: assert property (
        periph_rise && stretch && cnt_reg != '0 && ratio_reg != '0
        |=> core_reg && cnt_reg == $past(cnt_reg))
        else $error("core clock not held high during stretch");
    a_low_one_period: assert property (
        periph_rise && cnt_reg == '0 && ratio_reg != '0 && presc != '0 |=> core_reg)
        else $error("core low phase longer than one period");
    a_count_bound: assert property (
        cnt_reg <= ratio_reg)
        else $error("prescaler count past ratio");
endmodule : core_prescaler
`default_nettype wire

// File: reset_sequencer.sv
// Reset pin synchroniser, watchdog reset and reset exit delay
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer
    import clk_rst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic wdog_expire,
    input wire logic osc_rise,
    output logic in_reset
);
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic rst_reg;
    logic rst_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;

    // Enter on low pin or watchdog; leave after the exit delay
    always_comb begin
        rst_next = rst_reg;
        cnt_next = cnt_reg;
        if (!pin_s2_reg || wdog_expire) begin
            rst_next = 1'b1;
            cnt_next = '0;
        end else if (rst_reg && osc_rise) begin
            if (cnt_reg == EXIT_PERIODS - 7'h01) begin
                rst_next = 1'b0;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // Two-stage pin synchroniser and state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            rst_reg <= 1'b1;
            cnt_reg <= '0;
        end else begin
            pin_s1_reg <= reset_pin_n;
            pin_s2_reg <= pin_s1_reg;
            rst_reg <= rst_next;
            cnt_reg <= cnt_next;
        end
    end

    assign in_reset = rst_reg;

    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_wdog_enters: assert property (
        wdog_expire |=> rst_reg)
        else $error("watchdog expiry did not reset");
    a_pin_synced: assert property (
        !reset_pin_n [*3] |=> rst_reg)
        else $error("low reset pin not seen after sync");
    a_exit_delay: assert property (
        $fell(rst_reg) |-> $past(cnt_reg) == EXIT_PERIODS - 7'h01 && $past(osc_rise))
        else $error("reset left before the exit delay");
endmodule : reset_sequencer
`default_nettype wire

// File: clock_and_reset_generator.sv
// Clock and reset generator top: clocks, halt, reset strobes and vector fetch
`timescale 1ns/100ps
`default_nettype none
module clock_and_reset_generator
    import clk_rst_pkg::*;
#(
    parameter logic ROMLESS = 1'b0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic osc_input_pin,
    output logic osc_output_pin,
    input wire logic reset_pin_n,
    input wire logic watchdog_enable_bit,
    input wire logic watchdog_expired,
    input wire logic halt_req,
    input wire logic mem_wait_req,
    input wire logic bus_req,
    input wire logic wfi_req,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic oscillator_clock,
    output logic divided_clock,
    output logic peripheral_clock,
    output logic core_clock,
    output logic sys_reset,
    output reg_init_t reg_init,
    input wire logic bus_as_n,
    input wire logic bus_ds_n,
    input wire logic bus_rw_n,
    output logic address_strobe_n,
    output logic data_strobe_n,
    input wire logic read_write_in,
    output logic read_write_out,
    output logic read_write_oe,
    output logic [15:0] pmem_addr,
    output logic pmem_rd,
    input wire logic [7:0] pmem_rdata,
    output logic exec_start,
    output logic [15:0] exec_addr,
    output logic ext_mem_mode
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic in_reset;
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    clk_cfg_t cfg;
    logic osc_prev_reg;
    logic osc_clk_reg;
    logic osc_clk_next;
    logic osc_out_reg;
    logic osc_out_next;
    logic halted_reg;
    logic halted_next;
    logic osc_rise;
    logic div_reg;
    logic div_next;
    logic halve_act_reg;
    logic halve_act_next;
    logic periph_rise;
    logic stretch;
    logic wdog_expire;
    logic rw_prev_reg;
    logic rw_rise;
    logic [3:0] as_cnt_reg;
    logic [3:0] as_cnt_next;
    logic as_reg;
    logic as_next;
    logic ds_reg;
    logic ds_next;
    logic rw_out_reg;
    logic rw_oe_reg;
    vec_state_t vstate_reg;
    vec_state_t vstate_next;
    logic [15:0] paddr_reg;
    logic [15:0] paddr_next;
    logic [7:0] vhi_reg;
    logic [7:0] vhi_next;
    logic [15:0] eaddr_reg;
    logic [15:0] eaddr_next;
    logic estart_reg;
    logic estart_next;
    logic ext_mode_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources
    // Watchdog expiry only counts while the watchdog is on; pin never driven
    assign wdog_expire = watchdog_expired & watchdog_enable_bit;

    reset_sequencer u_reset_sequencer (
        .clk_sys(clk_sys),
        .srst(srst),
        .reset_pin_n(reset_pin_n),
        .wdog_expire(wdog_expire),
        .osc_rise(osc_rise),
        .in_reset(in_reset)
    );

    assign sys_reset = in_reset;
    assign reg_init = REG_INIT;

    ////////////////////////////////////////////////////////////////////////////
    // Mode and clock control register
    assign cfg = decode_mode(mode_reg);

    // Write port and registered read port
    always_comb begin
        mode_next = mode_reg;
        if (in_reset) begin
            mode_next = MODE_RST;
        end else if (reg_wr && reg_addr == MODE_ADDR) begin
            mode_next = reg_wdata;
        end
        rdata_next = (reg_addr == MODE_ADDR) ? mode_reg : 8'h00;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_reg <= MODE_RST;
            rdata_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator and halt
    assign osc_rise = osc_input_pin & ~osc_prev_reg & ~halted_reg;

    // Halt stops the oscillator unless the watchdog is on; reset restarts it
    always_comb begin
        halted_next = halted_reg;
        if (in_reset) begin
            halted_next = 1'b0;
        end else if (halt_req && !watchdog_enable_bit) begin
            halted_next = 1'b1;
        end
        osc_clk_next = halted_next ? 1'b1 : osc_input_pin;
        osc_out_next = halted_next ? 1'b0 : ~osc_input_pin;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            osc_prev_reg <= 1'b0;
            halted_reg <= 1'b0;
            osc_clk_reg <= 1'b0;
            osc_out_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_input_pin;
            halted_reg <= halted_next;
            osc_clk_reg <= osc_clk_next;
            osc_out_reg <= osc_out_next;
        end
    end

    assign oscillator_clock = osc_clk_reg;
    assign osc_output_pin = osc_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Divide by two; the halve setting is taken just before a rising edge
    always_comb begin
        halve_act_next = halve_act_reg;
        if (osc_rise && !div_reg) begin
            halve_act_next = cfg.halve;
        end
        if (halve_act_reg) begin
            div_next = osc_rise ? ~div_reg : div_reg;
        end else begin
            div_next = osc_clk_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            halve_act_reg <= 1'b1;
            div_reg <= 1'b0;
        end else begin
            halve_act_reg <= halve_act_next;
            div_reg <= div_next;
        end
    end

    assign periph_rise = div_next & ~div_reg;
    assign divided_clock = div_reg;
    assign peripheral_clock = div_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Core clock; peripherals never see the prescaler
    assign stretch = mem_wait_req | bus_req | wfi_req | (ROMLESS & pmem_rd);

    core_prescaler u_core_prescaler (
        .clk_sys(clk_sys),
        .srst(srst),
        .periph_clk(div_reg),
        .periph_rise(periph_rise),
        .presc(cfg.presc),
        .stretch(stretch),
        .core_clk(core_clock)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes; in reset the address strobe is a slow phase reference
    assign rw_rise = read_write_in & ~rw_prev_reg;

    // A master edge on read/write restarts the local strobe phase
    always_comb begin
        as_cnt_next = as_cnt_reg;
        as_next = as_reg;
        if (in_reset) begin
            if (rw_rise) begin
                as_cnt_next = 4'h0;
                as_next = 1'b1;
            end else if (osc_rise) begin
                if (as_cnt_reg == AS_HALF_LAST) begin
                    as_cnt_next = 4'h0;
                    as_next = ~as_reg;
                end else begin
                    as_cnt_next = as_cnt_reg + 1'b1;
                end
            end
        end else begin
            as_cnt_next = 4'h0;
            as_next = bus_as_n;
        end
        if (in_reset) begin
            ds_next = 1'b0;
        end else if (vstate_reg == V_IDLE) begin
            ds_next = 1'b1;
        end else begin
            ds_next = bus_ds_n;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rw_prev_reg <= 1'b1;
            as_cnt_reg <= 4'h0;
            as_reg <= 1'b1;
            ds_reg <= 1'b0;
            rw_out_reg <= 1'b1;
            rw_oe_reg <= 1'b0;
        end else begin
            rw_prev_reg <= read_write_in;
            as_cnt_reg <= as_cnt_next;
            as_reg <= as_next;
            ds_reg <= ds_next;
            rw_out_reg <= bus_rw_n;
            rw_oe_reg <= ~in_reset;
        end
    end

    assign address_strobe_n = as_reg;
    assign data_strobe_n = ds_reg;
    assign read_write_out = rw_out_reg;
    assign read_write_oe = rw_oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Reset vector fetch; read data arrives one cycle after the address
    always_comb begin
        vstate_next = vstate_reg;
        paddr_next = paddr_reg;
        vhi_next = vhi_reg;
        eaddr_next = eaddr_reg;
        estart_next = 1'b0;
        if (in_reset) begin
            vstate_next = V_IDLE;
        end else begin
            unique case (vstate_reg)
                V_IDLE: begin
                    vstate_next = V_RD0;
                    paddr_next = VEC_HI_ADDR;
                end
                V_RD0: begin
                    vstate_next = V_RD1;
                    paddr_next = VEC_LO_ADDR;
                end
                V_RD1: begin
                    vstate_next = V_LOAD;
                    vhi_next = pmem_rdata;
                end
                V_LOAD: begin
                    vstate_next = V_RUN;
                    eaddr_next = {vhi_reg, pmem_rdata};
                    estart_next = 1'b1;
                end
                V_RUN: begin
                    vstate_next = V_RUN;
                end
                default: begin
                    vstate_next = V_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            vstate_reg <= V_IDLE;
            paddr_reg <= 16'h0000;
            vhi_reg <= 8'h00;
            eaddr_reg <= 16'h0000;
            estart_reg <= 1'b0;
            ext_mode_reg <= 1'b0;
        end else begin
            vstate_reg <= vstate_next;
            paddr_reg <= paddr_next;
            vhi_reg <= vhi_next;
            eaddr_reg <= eaddr_next;
            estart_reg <= estart_next;
            ext_mode_reg <= in_reset ? 1'b0 : ROMLESS;
        end
    end

    assign pmem_rd = (vstate_reg == V_RD0) || (vstate_reg == V_RD1);
    assign pmem_addr = paddr_reg;
    assign exec_start = estart_reg;
    assign exec_addr = eaddr_reg;
    assign ext_mem_mode = ext_mode_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_fetch_hi;
        pmem_rd && pmem_addr == VEC_HI_ADDR;
    endsequence

    sequence s_fetch_lo;
        pmem_rd && pmem_addr == VEC_LO_ADDR;
    endsequence

    a_osc_follows_pin: assert property (
        !halted_reg |-> oscillator_clock == $past(osc_input_pin))
        else $error("oscillator clock does not follow pin");
    a_halt_stops_osc: assert property (
        halted_reg |-> oscillator_clock && !osc_output_pin)
        else $error("halt did not stop the oscillator");
    a_wdog_no_halt: assert property (
        halt_req && watchdog_enable_bit && !halted_reg |=> !halted_reg)
        else $error("halt taken with watchdog on");
    a_halve_off_pass: assert property (
        !$past(halve_act_reg) |-> divided_clock == oscillator_clock)
        else $error("undivided clock differs from oscillator clock");
    a_halve_on_toggle: assert property (
        $past(halve_act_reg) && !$past(osc_rise) |-> $stable(divided_clock))
        else $error("halved clock moved without oscillator edge");
    a_mode_reset_val: assert property (
        sys_reset |=> mode_reg == MODE_RST)
        else $error("mode register not at reset value");
    a_ds_low_reset: assert property (
        sys_reset |=> !data_strobe_n)
        else $error("data strobe not low in reset");
    a_as_divider: assert property (
        sys_reset && !rw_rise && osc_rise && as_cnt_reg == AS_HALF_LAST
        |=> address_strobe_n != $past(address_strobe_n))
        else $error("address strobe did not toggle");
    a_slave_align: assert property (
        sys_reset && rw_rise |=> address_strobe_n && as_cnt_reg == 4'h0)
        else $error("strobe phase not aligned to master");
    a_rw_input_reset: assert property (
        sys_reset |=> !read_write_oe)
        else $error("read/write driven in reset");
    a_ds_release: assert property (
        $fell(sys_reset) |=> data_strobe_n)
        else $error("data strobe not released at reset exit");
    a_vector_fetch: assert property (
        $fell(sys_reset) |-> ##1 s_fetch_hi ##1 s_fetch_lo ##2 exec_start)
        else $error("reset vector fetch sequence wrong");
endmodule : clock_and_reset_generator
`default_nettype wire

// File: ext_source.sv
// Oscillator pulse source, reset circuit and program memory model
`timescale 1ns/100ps
`default_nettype none
module ext_source (
    input wire logic clk_sys,
    input wire logic hold,
    input wire logic pmem_rd,
    input wire logic [15:0] pmem_addr,
    output logic osc_input_pin,
    output logic reset_pin_n,
    output logic [7:0] pmem_rdata
);
    logic [1:0] ph_reg;
    logic [10:0] low_reg;
    initial begin
        ph_reg = 2'h0;
        low_reg = 11'h000;
        osc_input_pin = 1'b0;
        reset_pin_n = 1'b0;
        pmem_rdata = 8'h00;
    end
    // Free-running pulse source, four system cycles a period
    always @(posedge clk_sys) begin
        ph_reg <= ph_reg + 2'h1;
        osc_input_pin <= ph_reg[1];
    end
    // Pin stays low at least 992 oscillator periods
    always @(posedge clk_sys) begin
        if (reset_pin_n) low_reg <= 11'h000;
        else if (ph_reg == 2'h3 && low_reg != 11'h3E0) low_reg <= low_reg + 11'h001;
        reset_pin_n <= !hold && (low_reg == 11'h3E0 || reset_pin_n);
    end
    // Byte one cycle after a read, a changing value otherwise
    always @(posedge clk_sys)
        pmem_rdata <= pmem_rd ? {4'hA, pmem_addr[3:0]} : ~pmem_rdata;
endmodule : ext_source
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the clock and reset generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import clk_rst_pkg::*;
    logic clk_sys = 1'b0, srst = 1'b1, hold = 1'b1, wd_en = 1'b0, wd_exp = 1'b0;
    logic halt = 1'b0, wr = 1'b0, rw_drv = 1'b1;
    logic [2:0] stall = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, pm_rdata;
    logic osc_in, rst_n, osc_out, oclk, dclk, pclk, cclk, sys_rst, as_n, ds_n;
    logic rw_out, rw_oe, pm_rd, ex_go, ext_mem;
    logic [15:0] pm_addr, ex_addr;
    reg_init_t init_v;
    wire logic rw_pin = rw_oe ? rw_out : rw_drv;
    int err_count = 0, total_checks = 0, n_o, n_p, n_c, n_a;
    ////////////////////////////////////////////////////////////////////////////
    // System clock, 40 ns period
    always #20 clk_sys = ~clk_sys;
    clock_and_reset_generator dut_u (.clk_sys(clk_sys), .srst(srst), .osc_input_pin(osc_in),
        .osc_output_pin(osc_out), .reset_pin_n(rst_n), .watchdog_enable_bit(wd_en),
        .watchdog_expired(wd_exp), .halt_req(halt), .mem_wait_req(stall[0]), .bus_req(stall[1]),
        .wfi_req(stall[2]), .reg_addr(MODE_ADDR), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rdata(rdata), .oscillator_clock(oclk), .divided_clock(dclk),
        .peripheral_clock(pclk), .core_clock(cclk), .sys_reset(sys_rst), .reg_init(init_v),
        .bus_as_n(1'b1), .bus_ds_n(1'b1), .bus_rw_n(1'b1), .address_strobe_n(as_n),
        .data_strobe_n(ds_n), .read_write_in(rw_pin), .read_write_out(rw_out),
        .read_write_oe(rw_oe), .pmem_addr(pm_addr), .pmem_rd(pm_rd), .pmem_rdata(pm_rdata),
        .exec_start(ex_go), .exec_addr(ex_addr), .ext_mem_mode(ext_mem));
    ext_source src_u (.clk_sys(clk_sys), .hold(hold), .pmem_rd(pm_rd), .pmem_addr(pm_addr),
        .osc_input_pin(osc_in), .reset_pin_n(rst_n), .pmem_rdata(pm_rdata));
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] in_rng(input int v, input int lo, input int hi);
        return 16'(v >= lo && v <= hi);
    endfunction : in_rng
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // Bounded wait for the internal reset level
    task automatic wait_rst(input logic lvl);
        for (int i = 0; i < 6000 && sys_rst !== lvl; i++) tick(1);
        if (sys_rst !== lvl) begin
            check(sys_rst, lvl);
            results();
        end
    endtask : wait_rst
    // A wait that ran out counts a mismatch and ends the run
    task automatic bound(input logic ok);
        if (ok !== 1'b1) begin
            check(ok, 1'b1);
            results();
        end
    endtask : bound
    // Count rising edges of the clocks and strobe toggles
    task automatic count(input int n);
        logic o, p, c, a;
        n_o = 0; n_p = 0; n_c = 0; n_a = 0;
        repeat (n) begin
            o = oclk; p = pclk; c = cclk; a = as_n;
            tick(1);
            n_o += int'(!o && oclk); n_p += int'(!p && pclk);
            n_c += int'(!c && cclk); n_a += int'(a != as_n);
        end
    endtask : count
    task automatic wr_mode(input logic [7:0] v);
        @(posedge clk_sys);
        wr <= 1'b1;
        wdata <= v;
        @(posedge clk_sys);
        wr <= 1'b0;
        tick(2);
    endtask : wr_mode
    ////////////////////////////////////////////////////////////////////////////
    // Reset state, refused write, strobe divider, slave alignment
    task automatic t_reset;
        tick(2);
        wr_mode(8'h00);
        check(rdata, MODE_RST);
        check(ds_n, 1'b0);
        check(rw_oe, 1'b0);
        check(init_v, REG_INIT);
        count(640);
        check(in_rng(n_a, 9, 11), 16'h0001);
        for (int i = 0; i < 200 && as_n !== 1'b1; i++) tick(1);
        for (int i = 0; i < 200 && as_n !== 1'b0; i++) tick(1);
        bound(as_n === 1'b0);
        @(posedge clk_sys);
        rw_drv <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rw_drv <= 1'b1;
        tick(2);
        check(as_n, 1'b1);
        $display("reset state done");
    endtask : t_reset
    // Exit delay, data strobe release, vector fetch
    task automatic t_exit;
        logic o;
        hold <= 1'b0;
        for (int i = 0; i < 5000 && rst_n !== 1'b1; i++) tick(1);
        bound(rst_n === 1'b1);
        n_o = 0;
        for (int i = 0; i < 400 && sys_rst !== 1'b0; i++) begin
            o = oclk;
            tick(1);
            n_o += int'(!o && oclk);
        end
        bound(sys_rst === 1'b0);
        check(in_rng(n_o, 66, 69), 16'h0001);
        tick(1);
        check(ds_n, 1'b1);
        for (int i = 0; i < 10 && ex_go !== 1'b1; i++) tick(1);
        bound(ex_go === 1'b1);
        check(ex_addr, 16'hA0A1);
        check({rw_oe, rw_out}, 2'b11);
        check(ext_mem, 1'b0);
        $display("reset exit done");
    endtask : t_exit
    // Every prescale code, halving, and stretch by memory wait, bus request and wait for interrupt
    task automatic t_clocks;
        for (int k = 0; k < 8; k++) begin
            wr_mode({3'b000, 3'(k), 2'b00});
            check(rdata, {3'b000, 3'(k), 2'b00});
            count(40);
            count(400);
            check(16'(n_p), 16'(n_o));
            check(in_rng(n_c * (k + 1), n_p - k - 1, n_p + k + 1), 16'h0001);
        end
        wr_mode(8'h20);
        check(rdata, 8'h20);
        count(40);
        count(400);
        check(in_rng(n_p * 2, n_o - 2, n_o + 2), 16'h0001);
        check(dclk, pclk);
        // One stall source at a time; the last pass runs prescaled by four
        for (int m = 0; m < 3; m++) begin
            wr_mode(m == 2 ? 8'h0C : 8'h00);
            @(posedge clk_sys);
            stall <= 3'h1 << m;
            tick(8);
            count(40);
            check(16'(n_c), 16'h0000);
            check(cclk, 1'b1);
            @(posedge clk_sys);
            stall <= 3'h0;
            count(40);
            check(in_rng(n_c, m == 2 ? 2 : 9, m == 2 ? 3 : 11), 16'h0001);
        end
        $display("clocks done");
    endtask : t_clocks
    // Halt under watchdog, watchdog reset, halt stop and pin restart
    task automatic t_halt;
        @(posedge clk_sys);
        wd_en <= 1'b1;
        halt <= 1'b1;
        @(posedge clk_sys);
        halt <= 1'b0;
        count(100);
        check(in_rng(n_o, 20, 30), 16'h0001);
        @(posedge clk_sys);
        wd_exp <= 1'b1;
        @(posedge clk_sys);
        wd_exp <= 1'b0;
        wd_en <= 1'b0;
        tick(1);
        check(sys_rst, 1'b1);
        check(rst_n, 1'b1);
        wait_rst(1'b0);
        @(posedge clk_sys);
        halt <= 1'b1;
        @(posedge clk_sys);
        halt <= 1'b0;
        count(50);
        check(16'(n_o), 16'h0000);
        check({oclk, osc_out}, 2'b10);
        hold <= 1'b1;
        wait_rst(1'b1);
        hold <= 1'b0;
        wait_rst(1'b0);
        count(100);
        check(in_rng(n_o, 20, 30), 16'h0001);
        $display("halt done");
    endtask : t_halt
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset();
        t_exit();
        t_clocks();
        t_halt();
        results();
    end
endmodule : tb_top
`default_nettype wire
